// ==== design/sirx_defs.svh ====
`ifndef SIRX_DEFS_SVH
`define SIRX_DEFS_SVH

// ----------------------------------------
// clock and bit rates, in Hz
// ----------------------------------------
`define SIRX_CLK_HZ 10000000
`define SIRX_RATE_115K2 115200
`define SIRX_RATE_57K6 57600
`define SIRX_RATE_38K4 38400
`define SIRX_RATE_19K2 19200
`define SIRX_RATE_14K4 14400
`define SIRX_RATE_12K8 12800
`define SIRX_RATE_9K6 9600
`define SIRX_RATE_7K2 7200
`define SIRX_RATE_4K8 4800
`define SIRX_RATE_3K6 3600
`define SIRX_RATE_2K4 2400
`define SIRX_RATE_1K8 1800
`define SIRX_RATE_1K2 1200

// ----------------------------------------
// rate select codes
// ----------------------------------------
`define SIRX_SEL_115K2 4'h0
`define SIRX_SEL_57K6 4'h1
`define SIRX_SEL_38K4 4'h2
`define SIRX_SEL_19K2 4'h3
`define SIRX_SEL_14K4 4'h4
`define SIRX_SEL_12K8 4'h5
`define SIRX_SEL_9K6 4'h6
`define SIRX_SEL_7K2 4'h7
`define SIRX_SEL_4K8 4'h8
`define SIRX_SEL_3K6 4'h9
`define SIRX_SEL_2K4 4'hA
`define SIRX_SEL_1K8 4'hB
`define SIRX_SEL_1K2 4'hC

// ----------------------------------------
// widths, depths, reset values
// ----------------------------------------
`define SIRX_CNT_W 14
`define SIRX_FIFO_DEPTH 16
`define SIRX_ECHO_SUPPRESS_RST 1'b1
`define SIRX_NRZ_IDLE 1'b1
`define SIRX_CNT_ZERO 14'h0000
`define SIRX_CNT_ONE 14'h0001

`endif

// ==== design/sirx_pkg.sv ====
`include "sirx_defs.svh"

package sirx_pkg;

  // one detected receive pulse: length of the zero bit to emit
  typedef struct packed {
    logic [`SIRX_CNT_W-1:0] bitCycles;
    logic [3:0] rateSel;
  } sirx_tok_t;

  typedef enum logic {
    SIRX_IDLE = 1'b0,
    SIRX_MARK = 1'b1
  } sirx_state_t;

endpackage : sirx_pkg

// ==== design/sirx_rx_echo.sv ====
// Summary of operation
// - while transmitting with echo suppression on, the receive line is blocked by the tx signal.
// - echo control switches the gating; low passes echo for self-test.
// - from reset until reprogrammed, echo suppression is active.
// - at 115.2 kbit/s pulses stretch to full bit width, with a delay.
// - fixed pulses of about 2 us, any width, each give one full bit unless the queue is full.
`timescale 1ns/100ps

`include "sirx_defs.svh"

module sirx_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  wire logic doPush;
  wire logic doPop;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = mem[rdPtr_r];
  assign count_nxt = count_r + (AW+1)'(doPush) - (AW+1)'(doPop);

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= doPush ? wrPtr_r + AW'(1) : wrPtr_r;
      rdPtr_r <= doPop ? rdPtr_r + AW'(1) : rdPtr_r;
      count_r <= count_nxt;
    end
  end

endmodule : sirx_fifo

module sirx_rx_echo #(
  parameter int CLK_HZ = `SIRX_CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic irRxd_n,
  input wire logic txIrPulse,
  input wire logic echoCfgWr,
  input wire logic echoCfgVal,
  input wire logic [3:0] rateSel,
  output logic echoCtrlOut,
  output logic rxNrz,
  output logic rxOverrun
);

  localparam int TW = $bits(sirx_pkg::sirx_tok_t);

  // ----------------------------------------
  // bit period lookup
  // ----------------------------------------
  function automatic logic [`SIRX_CNT_W-1:0] bitCyc(input logic [3:0] sel);
    int rate;
    rate = `SIRX_RATE_115K2;
    case (sel)
      `SIRX_SEL_57K6: rate = `SIRX_RATE_57K6;
      `SIRX_SEL_38K4: rate = `SIRX_RATE_38K4;
      `SIRX_SEL_19K2: rate = `SIRX_RATE_19K2;
      `SIRX_SEL_14K4: rate = `SIRX_RATE_14K4;
      `SIRX_SEL_12K8: rate = `SIRX_RATE_12K8;
      `SIRX_SEL_9K6: rate = `SIRX_RATE_9K6;
      `SIRX_SEL_7K2: rate = `SIRX_RATE_7K2;
      `SIRX_SEL_4K8: rate = `SIRX_RATE_4K8;
      `SIRX_SEL_3K6: rate = `SIRX_RATE_3K6;
      `SIRX_SEL_2K4: rate = `SIRX_RATE_2K4;
      `SIRX_SEL_1K8: rate = `SIRX_RATE_1K8;
      `SIRX_SEL_1K2: rate = `SIRX_RATE_1K2;
      default: rate = `SIRX_RATE_115K2;
    endcase
    // every bit length rounds down, never below one cycle
    if (CLK_HZ / rate < 1) begin
      return `SIRX_CNT_ONE;
    end
    return `SIRX_CNT_W'(CLK_HZ / rate);
  endfunction : bitCyc

  // ----------------------------------------
  // echo control and pin synchroniser
  // ----------------------------------------
  logic echoCtrl_r;
  logic rxMeta_r;
  logic rxSync_r;
  logic pulseDly_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      echoCtrl_r <= `SIRX_ECHO_SUPPRESS_RST;
    end else if (echoCfgWr) begin
      echoCtrl_r <= echoCfgVal;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= irRxd_n;
      rxSync_r <= rxMeta_r;
    end
  end

  assign echoCtrlOut = echoCtrl_r;

  // gating sits after the synchroniser: the transmit pulse is on clk_sys
  wire logic echoBlock;
  wire logic rxPulse;
  wire logic pulseStart;
  assign echoBlock = echoCtrl_r && txIrPulse;
  assign rxPulse = !rxSync_r && !echoBlock;
  // edge only, so a long or short pulse yields one bit
  assign pulseStart = rxPulse && !pulseDly_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pulseDly_r <= 1'b0;
    end else begin
      pulseDly_r <= rxPulse;
    end
  end

  // ----------------------------------------
  // pulse queue
  // ----------------------------------------
  sirx_pkg::sirx_tok_t tokIn;
  sirx_pkg::sirx_tok_t tokOut;
  wire logic tokReady;
  wire logic tokValid;
  wire logic nrzTake;

  assign tokIn.bitCycles = bitCyc(rateSel);
  assign tokIn.rateSel = rateSel;

  sirx_fifo #(
    .WIDTH(TW),
    .DEPTH(`SIRX_FIFO_DEPTH)
  ) uFifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(pulseStart),
    .inReady(tokReady),
    .inData(tokIn),
    .outValid(tokValid),
    .outReady(nrzTake),
    .outData(tokOut)
  );

  // a pulse that finds the queue full is dropped and flagged
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxOverrun <= 1'b0;
    end else begin
      rxOverrun <= pulseStart && !tokReady;
    end
  end

  // ----------------------------------------
  // NRZ stretcher
  // ----------------------------------------
  sirx_pkg::sirx_state_t state_r;
  sirx_pkg::sirx_state_t state_nxt;
  logic [`SIRX_CNT_W-1:0] cnt_r;
  logic [`SIRX_CNT_W-1:0] cnt_nxt;
  logic nrz_nxt;
  wire logic bitDone;

  assign bitDone = (cnt_r == `SIRX_CNT_ONE);
  // next token taken on the last cycle so zeros run back to back
  assign nrzTake = (state_r == sirx_pkg::SIRX_IDLE) || bitDone;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    nrz_nxt = rxNrz;
    case (state_r)
      sirx_pkg::SIRX_IDLE: begin
        if (tokValid) begin
          state_nxt = sirx_pkg::SIRX_MARK;
          cnt_nxt = tokOut.bitCycles;
          nrz_nxt = !`SIRX_NRZ_IDLE;
        end
      end
      sirx_pkg::SIRX_MARK: begin
        cnt_nxt = cnt_r - `SIRX_CNT_ONE;
        if (bitDone) begin
          if (tokValid) begin
            cnt_nxt = tokOut.bitCycles;
          end else begin
            state_nxt = sirx_pkg::SIRX_IDLE;
            cnt_nxt = `SIRX_CNT_ZERO;
            nrz_nxt = `SIRX_NRZ_IDLE;
          end
        end
      end
      default: begin
        state_nxt = sirx_pkg::SIRX_IDLE;
        cnt_nxt = `SIRX_CNT_ZERO;
        nrz_nxt = `SIRX_NRZ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= sirx_pkg::SIRX_IDLE;
      cnt_r <= `SIRX_CNT_ZERO;
      rxNrz <= `SIRX_NRZ_IDLE;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rxNrz <= nrz_nxt;
    end
  end

endmodule : sirx_rx_echo

// ==== dv/sirx_rx_echo_properties.sv ====
`timescale 1ns/100ps
// ------
// checks
// ------
module sirx_rx_echo_chk #(
  parameter int CLK_HZ = 10000000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic irRxd_n,
  input wire logic txIrPulse,
  input wire logic echoCfgWr,
  input wire logic echoCfgVal,
  input wire logic echoCtrlOut,
  input wire logic rxNrz,
  input wire logic rxOverrun
);
  localparam int MIN_BIT = CLK_HZ / 115200;
  int lowCnt_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys) begin
    if (!rst_n || rxNrz) lowCnt_r <= 0;
    else lowCnt_r <= lowCnt_r + 1;
  end
  a_rst_default: assert property (disable iff (1'b0)
    !rst_n |=> echoCtrlOut && rxNrz && !rxOverrun) else $error("bad reset");
  a_cfg_load: assert property (
    echoCfgWr |=> echoCtrlOut == $past(echoCfgVal)) else $error("cfg lost");
  a_cfg_hold: assert property (
    !echoCfgWr |=> $stable(echoCtrlOut)) else $error("cfg moved");
  a_echo_block: assert property (
    $fell(rxNrz) |-> !$past(echoCtrlOut && txIrPulse, 2))
    else $error("echo leaked");
  a_fall_cause: assert property (
    $fell(rxNrz) |-> $past(irRxd_n, 3) == 1'b0) else $error("bit no pulse");
  a_min_width: assert property (
    $rose(rxNrz) |-> lowCnt_r >= MIN_BIT) else $error("bit too short");
  a_ovr_pulse: assert property (
    rxOverrun |-> !rxNrz ##1 !rxOverrun) else $error("overrun odd");
endmodule : sirx_rx_echo_chk

bind sirx_rx_echo sirx_rx_echo_chk #(.CLK_HZ(CLK_HZ)) u_sirx_rx_echo_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .irRxd_n(irRxd_n),
  .txIrPulse(txIrPulse), .echoCfgWr(echoCfgWr), .echoCfgVal(echoCfgVal),
  .echoCtrlOut(echoCtrlOut), .rxNrz(rxNrz), .rxOverrun(rxOverrun));

// ==== dv/sirx_xcvr_model.sv ====
`timescale 1ns/100ps
// ----------------------------------
// transceiver: fixed width, echoes tx
// ----------------------------------
module sirx_xcvr_model #(
  parameter int PW = 20,
  parameter int EW = 5
) (
  input wire logic clk_sys,
  input wire logic optIn,
  input wire logic txIrPulse,
  output logic irRxd_n
);
  int cnt = 0;
  int eCnt = 0;
  logic optD = 1'b0;
  logic txD = 1'b0;
  always @(posedge clk_sys) begin
    optD <= optIn;
    txD <= txIrPulse;
    // width fixed whatever the light lasts
    if (optIn && !optD) cnt <= PW;
    else if (cnt > 0) cnt <= cnt - 1;
    // echo-on part: own tx shows on rx
    if (txIrPulse && !txD) eCnt <= EW;
    else if (eCnt > 0) eCnt <= eCnt - 1;
  end
  assign irRxd_n = !(cnt > 0 || eCnt > 0);
endmodule : sirx_xcvr_model

// ==== dv/sirx_tb.sv ====
`timescale 1ns/100ps
`include "sirx_defs.svh"
module tb;
  localparam int HZ = 1000000;
  // wait longer than any receiver latency, 0.5 ms of the real clock
  localparam int LAT = `SIRX_CLK_HZ / 2000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic optIn = 1'b0;
  logic txIrPulse = 1'b0;
  logic echoCfgWr = 1'b0;
  logic echoCfgVal = 1'b0;
  logic [3:0] rateSel = 4'h0;
  logic irRxd_n, echoCtrlOut, rxNrz, rxOverrun;
  int errCount = 0, checks = 0, ovrTot = 0, lowLen = 0, ovr = 0, n, c;
  int expN[$], expC[$];
  logic [31:0] seed = 32'h00000048;
  int rates[13] = '{`SIRX_RATE_115K2, `SIRX_RATE_57K6, `SIRX_RATE_38K4,
    `SIRX_RATE_19K2, `SIRX_RATE_14K4, `SIRX_RATE_12K8, `SIRX_RATE_9K6,
    `SIRX_RATE_7K2, `SIRX_RATE_4K8, `SIRX_RATE_3K6, `SIRX_RATE_2K4,
    `SIRX_RATE_1K8, `SIRX_RATE_1K2};
  sirx_rx_echo #(.CLK_HZ(HZ)) u_sirx_rx_echo (.clk_sys(clk_sys),
    .rst_n(rst_n), .irRxd_n(irRxd_n), .txIrPulse(txIrPulse),
    .echoCfgWr(echoCfgWr), .echoCfgVal(echoCfgVal), .rateSel(rateSel),
    .echoCtrlOut(echoCtrlOut), .rxNrz(rxNrz), .rxOverrun(rxOverrun));
  sirx_xcvr_model u_sirx_xcvr_model (.clk_sys(clk_sys), .optIn(optIn),
    .txIrPulse(txIrPulse), .irRxd_n(irRxd_n));
  initial forever #50 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int bitc(input logic [3:0] s);
    return HZ / rates[s > 4'hC ? 0 : s];
  endfunction : bitc
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      errCount++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic light(input int hi, input int lo);
    optIn = 1'b1;
    tick(hi);
    optIn = 1'b0;
    tick(lo);
  endtask : light
  task automatic tx(input logic cfg, input int k);
    echoCfgWr = 1'b1;
    echoCfgVal = cfg;
    tick(1);
    echoCfgWr = 1'b0;
    chk(echoCtrlOut, cfg);
    repeat (k) begin
      txIrPulse = 1'b1;
      tick(16);
      txIrPulse = 1'b0;
      tick(30);
    end
  endtask : tx
  task automatic giveVerdict();
    chk(expN.size(), 0);
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : giveVerdict
  // ------------------------------------------
  // measures each low run; queued bits merge
  // ------------------------------------------
  always @(negedge clk_sys) begin
    if (rxNrz === 1'b0) begin
      lowLen++;
      ovr += rxOverrun;
    end else if (lowLen > 0) begin
      n = expN.size() ? expN.pop_front() : 0;
      c = expC.size() ? expC.pop_front() : 0;
      chk(lowLen, n * c);
      ovrTot += ovr;
      lowLen = 0;
      ovr = 0;
    end
  end
  initial begin
    tick(8);
    rst_n = 1'b1;
    chk({echoCtrlOut, rxNrz}, 2'h3);
    for (int s = 0; s < 16; s++) begin
      rateSel = s[3:0];
      expN.push_back(1);
      expC.push_back(bitc(s[3:0]));
      light(1 + int'(xs() % 60), 0);
      tick(bitc(s[3:0]) + 30);
    end
    $display("test rates done");
    rateSel = 4'h0;
    tx(1'b1, 3);
    rateSel = 4'(xs());
    expN.push_back(1);
    expC.push_back(bitc(rateSel));
    tx(1'b0, 1);
    tick(bitc(rateSel) + 20);
    tx(1'b1, 2);
    // last pulse sent: wait out the latency before taking frames
    tick(LAT);
    $display("test echo done");
    // slowest rate so one bit outlasts all 20 pulses: queue overflows
    rateSel = 4'hC;
    expN.push_back(1 + `SIRX_FIFO_DEPTH);
    expC.push_back(bitc(4'hC));
    repeat (20) light(10, 20);
    tick(20 * bitc(4'hC) + 50);
    chk(ovrTot, 20 - 1 - `SIRX_FIFO_DEPTH);
    $display("test overrun done");
    giveVerdict();
  end
  initial begin
    // about twice the planned run
    #(100 * 50000);
    errCount++;
    giveVerdict();
  end
endmodule : tb
